// file: smt_scanner.sv
// scanner operating mode control and text record builder
// assumes: register port on the same clock; pins (trigger, mux select,
// link strap) are asynchronous; acquisition answers each pass or poll
// with samples on the samp port; tx is drained by the link framer.
// Notes on behaviour
// - seven modes picked by mode write
// - power-up in analog unless default stored
// - default qualifier stores mode for power-up
// - analog mode answers polls, mux picks channel
// - normal mode: no analog, poll or stream
// - trigger mode: emit stream record per trigger
// - polled mode: refresh on trigger, send polled
// - stream mode only Ethernet, starts at startup
// - delayed streaming 30 s, default only
// - setup writes only in programming mode
// - poll answer: channel, colon, value
// - text formats fine below 40 sps
// - RS-485 sends each eight-channel group
// - Ethernet sends one packet per pass
// - text line: chan, colon, eight chars, CR
// - Ethernet text rate at most 125
// - percentage record: chan plus five digits
// - negative percentage leads with 9
// - Ethernet percentage rate at most 125
// - MODBUS reads data, reads/writes setup
// - single sample sends one packet
// - zero only in programming mode
// - timed stream; zero stops, omitted endless
`timescale 1ns/1ps

module smt_scanner
  import smt_pkg::*;
#(
  parameter int CYC_SEC = CYC_PER_SEC
) (
  input wire logic clock, // 125 MHz
  input wire logic srst, // sync reset, high
  input wire logic [AW-1:0] reg_addr, // register byte address
  input wire logic [DW-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [DW-1:0] reg_rdata, // read data, next cycle
  input wire logic link_is_eth_pin, // strap: high on Ethernet unit
  input wire logic trigger_pin, // trigger input
  input wire logic [5:0] mux_sel_pin, // analog multiplexer select
  input wire logic [2:0] saved_mode, // stored power-on mode
  output logic [2:0] stored_default, // mode to keep for power-up
  output logic stored_default_wr, // pulse: save stored_default
  output logic analog_en, // analog output enabled
  output logic [5:0] analog_chan, // analog channel shown
  output logic zero_pulse, // pulse: auto-zero sensors
  output logic refresh, // acquisition may update data
  output logic acq_pass, // pulse: start one pass
  output logic poll_req, // pulse: fetch one channel
  output logic [5:0] poll_chan, // channel asked for
  output logic [15:0] data_rate, // samples per second
  output logic [15:0] user_gain, // setup gain
  output logic [15:0] user_offset, // setup offset
  input wire smt_sample_t samp, // sample from acquisition
  input wire logic samp_valid, // sample present
  output logic samp_ready, // sample taken
  output smt_tx_t tx, // byte out, last marks packet end
  output logic tx_valid, // byte present
  input wire logic tx_ready // byte taken
);

  typedef enum logic {S_IDLE, S_SEND} smt_state_t;

  smt_mode_t mode;
  smt_fmt_t fmt;
  smt_state_t state;
  logic eth_s1, eth_s2, is_eth;
  logic trig_s1, trig_s2, trig_s3, trig_edge;
  logic [5:0] mux_s1, mux_s2;
  logic [1:0] boot_cnt;
  logic boot_load;
  logic stream_on, stream_endless, delay_wait;
  logic [15:0] sec_left;
  logic [5:0] delay_cnt;
  logic [31:0] cyc_cnt;
  logic sec_tick;
  logic pass_busy, one_shot, trig_pend, poll_pend;
  logic wr_mode, wr_cmd, wr_stream, in_prog;
  smt_mode_t wmode;
  logic wdef, mode_ok;
  logic [7:0] line [LINE_MAX];
  logic [7:0] next_line [LINE_MAX];
  logic [3:0] line_len, next_len, idx;
  logic line_last, next_last;
  logic [5:0] ctens, cones;
  logic [2:0] dp_c;
  int k;

  // pin synchronisers
  always_ff @(posedge clock) begin
    eth_s1 <= link_is_eth_pin;
    eth_s2 <= eth_s1;
    trig_s1 <= trigger_pin;
    trig_s2 <= trig_s1;
    trig_s3 <= trig_s2;
    mux_s1 <= mux_sel_pin;
    mux_s2 <= mux_s1;
  end

  assign trig_edge = trig_s2 & ~trig_s3;

  // strap and stored default are taken once the sync chain has settled
  always_ff @(posedge clock) begin
    if (srst) begin
      boot_cnt <= 2'h0;
      is_eth <= 1'b0;
    end else begin
      if (boot_cnt != 2'h3) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
      if (boot_cnt == 2'h2) begin
        is_eth <= eth_s2;
      end
    end
  end

  assign boot_load = (boot_cnt == 2'h2);
  assign in_prog = (mode == MODE_PROG);
  assign wr_mode = reg_wr && (reg_addr == OFS_MODE);
  assign wr_cmd = reg_wr && (reg_addr == OFS_CMD);
  assign wr_stream = reg_wr && (reg_addr == OFS_STREAM);
  assign wmode = smt_mode_t'(reg_wdata[2:0]);
  assign wdef = reg_wdata[MODE_DEF_BIT];

  // no Ethernet-less stream mode; delayed streaming only as a default
  always_comb begin
    mode_ok = (reg_wdata[2:0] <= 3'(MODE_PROG));
    if (wmode == MODE_STREAM && !is_eth) begin
      mode_ok = 1'b0;
    end
    if (wmode == MODE_DELAY && !wdef) begin
      mode_ok = 1'b0;
    end
  end

  // one-second tick
  always_ff @(posedge clock) begin
    if (srst || cyc_cnt == 32'(CYC_SEC - 1)) begin
      cyc_cnt <= 32'h0;
    end else begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  assign sec_tick = (cyc_cnt == 32'(CYC_SEC - 1));

  // operating mode and power-on default
  always_ff @(posedge clock) begin
    if (srst) begin
      mode <= MODE_ANALOG;
      stored_default <= 3'(MODE_ANALOG);
      stored_default_wr <= 1'b0;
    end else begin
      stored_default_wr <= 1'b0;
      if (boot_load) begin
        stored_default <= saved_mode;
        if (saved_mode > 3'(MODE_PROG)) begin
          mode <= MODE_ANALOG;
        end else if (saved_mode == 3'(MODE_STREAM) && !eth_s2) begin
          mode <= MODE_ANALOG;
        end else begin
          mode <= smt_mode_t'(saved_mode);
        end
      end else if (wr_mode && mode_ok) begin
        if (wdef) begin
          stored_default <= reg_wdata[2:0];
          stored_default_wr <= 1'b1;
        end
        if (wmode != MODE_DELAY) begin
          mode <= wmode;
        end
      end
    end
  end

  // analog path
  always_ff @(posedge clock) begin
    if (srst) begin
      analog_en <= 1'b0;
      analog_chan <= 6'h00;
    end else begin
      analog_en <= (mode == MODE_ANALOG);
      analog_chan <= mux_s2;
    end
  end

  // setup registers
  always_ff @(posedge clock) begin
    if (srst) begin
      fmt <= FMT_TEXT;
      data_rate <= RATE_RST;
      user_gain <= GAIN_RST;
      user_offset <= OFFSET_RST;
    end else if (reg_wr && in_prog) begin
      if (reg_addr == OFS_FORMAT) begin
        fmt <= smt_fmt_t'(reg_wdata[0]);
      end
      if (reg_addr == OFS_RATE) begin
        if (is_eth && reg_wdata[15:0] > TEXT_ETH_MAX_RATE) begin
          data_rate <= TEXT_ETH_MAX_RATE;
        end else begin
          data_rate <= reg_wdata[15:0];
        end
      end
      if (reg_addr == OFS_GAIN) begin
        user_gain <= reg_wdata[15:0];
      end
      if (reg_addr == OFS_OFFSET) begin
        user_offset <= reg_wdata[15:0];
      end
    end
  end

  // streaming state
  always_ff @(posedge clock) begin
    if (srst) begin
      stream_on <= 1'b0;
      stream_endless <= 1'b0;
      sec_left <= 16'h0000;
      delay_wait <= 1'b0;
      delay_cnt <= 6'h00;
    end else if (boot_load) begin
      stream_on <= (saved_mode == 3'(MODE_STREAM)) && eth_s2;
      stream_endless <= 1'b1;
      delay_wait <= (saved_mode == 3'(MODE_DELAY));
      delay_cnt <= 6'h00;
    end else if (wr_mode && mode_ok && wmode != MODE_DELAY) begin
      stream_on <= (wmode == MODE_STREAM);
      stream_endless <= 1'b1;
      delay_wait <= 1'b0;
    end else if (wr_stream && (mode == MODE_NORMAL || mode == MODE_STREAM)) begin
      if (reg_wdata[STREAM_ENDLESS_BIT]) begin
        stream_on <= is_eth;
        stream_endless <= 1'b1;
      end else begin
        stream_on <= (reg_wdata[15:0] != 16'h0000);
        stream_endless <= 1'b0;
        sec_left <= reg_wdata[15:0];
      end
    end else if (sec_tick) begin
      if (delay_wait) begin
        if (delay_cnt == DELAY_S - 6'h01) begin
          delay_wait <= 1'b0;
          stream_on <= 1'b1;
          stream_endless <= 1'b1;
        end
        delay_cnt <= delay_cnt + 6'h01;
      end
      if (stream_on && !stream_endless) begin
        sec_left <= sec_left - 16'h0001;
        if (sec_left == 16'h0001) begin
          stream_on <= 1'b0;
        end
      end
    end
  end

  // pass and poll requests; one outstanding at a time
  always_ff @(posedge clock) begin
    if (srst) begin
      one_shot <= 1'b0;
      trig_pend <= 1'b0;
      poll_pend <= 1'b0;
      pass_busy <= 1'b0;
      acq_pass <= 1'b0;
      poll_req <= 1'b0;
      poll_chan <= 6'h00;
      zero_pulse <= 1'b0;
      refresh <= 1'b0;
    end else begin
      acq_pass <= 1'b0;
      poll_req <= 1'b0;
      zero_pulse <= wr_cmd && reg_wdata[CMD_ZERO_BIT] && in_prog;
      refresh <= (mode != MODE_POLLED) || trig_edge;
      if (wr_cmd && reg_wdata[CMD_POLL_BIT] && !poll_pend && !pass_busy) begin
        poll_pend <= 1'b1;
        poll_req <= 1'b1;
        poll_chan <= reg_wdata[CMD_CHAN_LSB +: 6];
      end else if (!pass_busy && !poll_pend
                   && (stream_on || one_shot || trig_pend)) begin
        pass_busy <= 1'b1;
        acq_pass <= 1'b1;
        one_shot <= 1'b0;
        trig_pend <= 1'b0;
      end
      if (samp_valid && samp_ready) begin
        if (poll_pend) begin
          poll_pend <= 1'b0;
        end else if (samp.pass_end) begin
          pass_busy <= 1'b0;
        end
      end
      if (wr_cmd && reg_wdata[CMD_SINGLE_BIT]) begin
        one_shot <= 1'b1;
      end
      if (trig_edge && mode == MODE_TRIGGER) begin
        trig_pend <= 1'b1;
      end
    end
  end

  // record builder
  always_comb begin
    k = 0;
    ctens = samp.chan / 6'h0A;
    cones = samp.chan % 6'h0A;
    dp_c = (samp.dp > 3'h6) ? 3'h6 : samp.dp;
    next_len = ENG_LEN;
    next_last = poll_pend || (is_eth ? samp.pass_end : samp.group_end);
    for (int i = 0; i < LINE_MAX; i++) begin
      next_line[i] = ASC_SPACE;
    end
    next_line[0] = ASC_0 + {2'h0, ctens};
    next_line[1] = ASC_0 + {2'h0, cones};
    if (fmt == FMT_PCT && !poll_pend) begin
      for (int i = 0; i < 5; i++) begin
        next_line[2 + i] = ASC_0 + {4'h0, samp.pct_bcd[4 * (4 - i) +: 4]};
      end
      if (samp.neg) begin
        next_line[2] = ASC_9;
      end
      next_line[7] = ASC_CR;
      next_len = PCT_LEN;
    end else begin
      next_line[2] = ASC_COLON;
      next_line[3] = samp.neg ? ASC_MINUS : ASC_SPACE;
      for (int i = 0; i < 7; i++) begin
        if (i == int'(dp_c)) begin
          next_line[4 + i] = ASC_DOT;
        end else begin
          k = (i < int'(dp_c)) ? i : i - 1;
          next_line[4 + i] = ASC_0 + {4'h0, samp.eng_bcd[4 * (5 - k) +: 4]};
        end
      end
      next_line[11] = ASC_CR;
    end
  end

  assign samp_ready = (state == S_IDLE);
  assign tx_valid = (state == S_SEND);
  assign tx = '{data: line[idx],
                last: line_last && (idx == line_len - 4'h1)};

  // byte sender
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= S_IDLE;
      idx <= 4'h0;
      line_len <= ENG_LEN;
      line_last <= 1'b0;
      for (int i = 0; i < LINE_MAX; i++) begin
        line[i] <= ASC_SPACE;
      end
    end else begin
      unique case (state)
        S_IDLE: begin
          if (samp_valid) begin
            line <= next_line;
            line_len <= next_len;
            line_last <= next_last;
            idx <= 4'h0;
            state <= S_SEND;
          end
        end
        S_SEND: begin
          if (tx_ready) begin
            if (idx == line_len - 4'h1) begin
              state <= S_IDLE;
            end else begin
              idx <= idx + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // register read
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_MODE: reg_rdata <= {25'h0, stored_default, 1'b0, mode};
        OFS_FORMAT: reg_rdata <= {31'h0, fmt};
        OFS_RATE: reg_rdata <= {16'h0, data_rate};
        OFS_GAIN: reg_rdata <= {16'h0, user_gain};
        OFS_OFFSET: reg_rdata <= {16'h0, user_offset};
        OFS_STATUS: reg_rdata <= {24'h0, data_rate >= ANY_FMT_RATE, delay_wait,
                                  poll_pend, analog_en, is_eth, pass_busy,
                                  stream_on, 1'b0};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: smt_pkg.sv
// package for the scanner mode controller and text record builder
// assumes a single 125 MHz clock domain and a plain register port
package smt_pkg;

  localparam int AW = 8;
  localparam int DW = 32;

  // register byte offsets
  localparam logic [AW-1:0] OFS_MODE = 8'h00;
  localparam logic [AW-1:0] OFS_FORMAT = 8'h04;
  localparam logic [AW-1:0] OFS_RATE = 8'h08;
  localparam logic [AW-1:0] OFS_GAIN = 8'h0C;
  localparam logic [AW-1:0] OFS_OFFSET = 8'h10;
  localparam logic [AW-1:0] OFS_CMD = 8'h14;
  localparam logic [AW-1:0] OFS_STREAM = 8'h18;
  localparam logic [AW-1:0] OFS_STATUS = 8'h1C;

  // field positions
  localparam int MODE_DEF_BIT = 3;
  localparam int MODE_STORED_LSB = 4;
  localparam int CMD_SINGLE_BIT = 0;
  localparam int CMD_ZERO_BIT = 1;
  localparam int CMD_POLL_BIT = 2;
  localparam int CMD_CHAN_LSB = 8;
  localparam int STREAM_ENDLESS_BIT = 16;

  // reset values
  localparam logic [15:0] RATE_RST = 16'h0001;
  localparam logic [15:0] GAIN_RST = 16'h0000;
  localparam logic [15:0] OFFSET_RST = 16'h0000;

  // rate limits in samples per second
  localparam logic [15:0] ANY_FMT_RATE = 16'h0028;
  localparam logic [15:0] TEXT_ETH_MAX_RATE = 16'h007D;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int SECOND_NS = 1000000000;
  localparam int CYC_PER_SEC = SECOND_NS / CLK_PERIOD_NS;
  localparam logic [5:0] DELAY_S = 6'h1E;

  // record layout
  localparam int LINE_MAX = 12;
  localparam logic [3:0] ENG_LEN = 4'hC;
  localparam logic [3:0] PCT_LEN = 4'h8;
  localparam logic [7:0] ASC_0 = 8'h30;
  localparam logic [7:0] ASC_9 = 8'h39;
  localparam logic [7:0] ASC_COLON = 8'h3A;
  localparam logic [7:0] ASC_DOT = 8'h2E;
  localparam logic [7:0] ASC_MINUS = 8'h2D;
  localparam logic [7:0] ASC_SPACE = 8'h20;
  localparam logic [7:0] ASC_CR = 8'h0D;

  typedef enum logic [2:0] {
    MODE_ANALOG, MODE_NORMAL, MODE_TRIGGER, MODE_POLLED,
    MODE_STREAM, MODE_DELAY, MODE_PROG
  } smt_mode_t;

  typedef enum logic {FMT_TEXT, FMT_PCT} smt_fmt_t;

  typedef struct packed {
    logic [5:0] chan;
    logic neg;
    logic [23:0] eng_bcd;
    logic [2:0] dp;
    logic [19:0] pct_bcd;
    logic group_end;
    logic pass_end;
  } smt_sample_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } smt_tx_t;

endpackage

// file: smt_scanner_assertions.sv
// port checker for the scanner mode and record block
// assumes one clock domain; bound into smt_scanner
`timescale 1ns/1ps
module smt_checker
  import smt_pkg::*;
(
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic [AW-1:0] reg_addr, // address
  input wire logic [DW-1:0] reg_wdata, // wdata
  input wire logic reg_wr, // write
  input wire logic reg_rd, // read
  input wire logic [DW-1:0] reg_rdata, // rdata
  input wire logic [5:0] mux_sel_pin, // mux
  input wire logic analog_en, // analog on
  input wire logic [5:0] analog_chan, // shown chan
  input wire logic zero_pulse, // zero
  input wire logic stored_default_wr, // save
  input wire logic poll_req, // poll
  input wire logic [15:0] data_rate, // rate
  input wire logic [15:0] user_gain, // gain
  input wire logic samp_ready, // taken
  input wire smt_tx_t tx, // byte
  input wire logic tx_valid, // valid
  input wire logic tx_ready // ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not idle");
  a_rate_guard: assert property ($changed(data_rate) |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_RATE && !$past(analog_en)) else $error("rate changed");
  a_gain_guard: assert property ($changed(user_gain) |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_GAIN && !$past(analog_en)) else $error("gain changed");
  a_zero_cause: assert property (zero_pulse |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_CMD && $past(reg_wdata[CMD_ZERO_BIT]) && !analog_en)
    else $error("zero without command");
  a_zero_once: assert property (zero_pulse |=> !zero_pulse)
    else $error("zero pulse too long");
  a_default_save: assert property (stored_default_wr |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_MODE && $past(reg_wdata[MODE_DEF_BIT]))
    else $error("default saved without qualifier");
  a_poll_cause: assert property (poll_req |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_CMD) else $error("poll without command");
  a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx))
    else $error("byte dropped while stalled");
  a_busy_refuse: assert property (tx_valid |-> !samp_ready)
    else $error("sample taken while sending");
  a_line_end: assert property (tx_valid && tx.last |-> tx.data == ASC_CR)
    else $error("packet end not a carriage return");
  a_mux_follow: assert property (analog_chan == $past(mux_sel_pin, 3))
    else $error("analog channel not following pins");
  c_packet: cover property (tx_valid && tx_ready && tx.last);
  c_zero: cover property (zero_pulse);
  c_poll: cover property (poll_req);
  c_save: cover property (stored_default_wr);
endmodule

bind smt_scanner smt_checker u_chk (.clock(clock), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .mux_sel_pin(mux_sel_pin), .analog_en(analog_en), .analog_chan(analog_chan),
  .zero_pulse(zero_pulse), .stored_default_wr(stored_default_wr), .poll_req(poll_req),
  .data_rate(data_rate), .user_gain(user_gain), .samp_ready(samp_ready), .tx(tx),
  .tx_valid(tx_valid), .tx_ready(tx_ready));

// file: smt_host_model.sv
// far-side model: answers passes and polls with samples, drains bytes
// assumes the scanner's samp and tx ports on the same clock
`timescale 1ns/1ps
module smt_host_model
  import smt_pkg::*;
(
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic acq_pass, // pass request
  input wire logic poll_req, // poll request
  input wire logic [5:0] poll_chan, // polled chan
  input wire logic neg, // next sample negative
  input wire logic slow, // stall sink
  input wire logic samp_ready, // taken
  output smt_sample_t samp, // sample
  output logic samp_valid, // present
  input wire smt_tx_t tx, // byte
  input wire logic tx_valid, // valid
  output logic tx_ready // ready
);
  logic [7:0] rx[$];
  logic rxl[$];
  logic tog;
  always_ff @(posedge clock) begin
    if (srst) begin
      samp_valid <= 1'b0;
      samp <= '0;
    end else if (acq_pass || poll_req) begin
      samp_valid <= 1'b1;
      samp <= '{chan: poll_req ? poll_chan : 6'h08, neg: neg, eng_bcd: 24'h034567,
        dp: 3'h4, pct_bcd: 20'h01234, group_end: 1'b1, pass_end: 1'b1};
    end else if (samp_valid && samp_ready) begin
      samp_valid <= 1'b0;
      // released lines do not keep their last value
      samp <= ~samp;
    end
  end
  always_ff @(posedge clock) begin
    tog <= srst ? 1'b0 : ~tog;
    if (tx_valid && tx_ready) begin
      rx.push_back(tx.data);
      rxl.push_back(tx.last);
    end
  end
  assign tx_ready = !slow || tog;
endmodule

// file: scanner_mode_and_text_output_bench.sv
// self-checking bench for the scanner mode and record block
// assumes smt_pkg, smt_scanner, smt_host_model and the checker
`timescale 1ns/1ps
module scanner_mode_and_text_output_bench
  import smt_pkg::*;
;
  logic clock, srst, reg_wr, reg_rd, eth, trig, slow, neg, sdw, analog_en, zero_pulse;
  logic refresh, acq_pass, poll_req, samp_valid, samp_ready, tx_valid, tx_ready;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata, reg_rdata, rv;
  logic [5:0] mux, analog_chan, poll_chan;
  logic [2:0] sdef, smode;
  logic [15:0] data_rate, user_gain;
  smt_sample_t samp;
  smt_tx_t tx;
  int errors, compares, nr;
  logic [2:0] ml[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6};

  smt_scanner #(.CYC_SEC(20)) DUT (.clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .link_is_eth_pin(eth), .trigger_pin(trig), .mux_sel_pin(mux), .saved_mode(smode),
    .stored_default(sdef), .stored_default_wr(sdw), .analog_en(analog_en),
    .analog_chan(analog_chan), .zero_pulse(zero_pulse), .refresh(refresh),
    .acq_pass(acq_pass), .poll_req(poll_req), .poll_chan(poll_chan),
    .data_rate(data_rate), .user_gain(user_gain), .user_offset(), .samp(samp),
    .samp_valid(samp_valid), .samp_ready(samp_ready), .tx(tx), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  smt_host_model host (.clock(clock), .srst(srst), .acq_pass(acq_pass),
    .poll_req(poll_req), .poll_chan(poll_chan), .neg(neg), .slow(slow),
    .samp_ready(samp_ready), .samp(samp), .samp_valid(samp_valid), .tx(tx),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // returns just after the edge that takes the write
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rec(input string s);
    int n;
    n = 0;
    while (host.rx.size() < s.len() && n < 400) begin
      @(posedge clock);
      #1 n++;
    end
    if (host.rx.size() < s.len()) begin
      errors++;
      report_and_stop();
    end
    for (int i = 0; i < s.len(); i++) begin
      chk("record byte", 32'(host.rx[i]), 32'(s[i]));
    end
    chk("record last", 32'(host.rxl[s.len() - 1]), 32'h1);
    host.rx.delete();
    host.rxl.delete();
  endtask

  // trigger pulse; counts cycles with refresh high meanwhile
  task automatic pulse;
    nr = 0;
    @(posedge clock) trig <= 1'b1;
    repeat (12) begin
      @(negedge clock);
      nr += int'(refresh);
    end
    @(posedge clock) trig <= 1'b0;
  endtask

  task automatic t_boot;
    chk("analog_en", analog_en, 1);
    chk("data_rate", data_rate, RATE_RST);
    rd(OFS_MODE, rv);
    chk("mode", rv[2:0], 3'h0);
    rd(8'h40, rv);
    chk("unmapped", rv, 0);
  endtask

  task automatic t_poll;
    @(posedge clock) mux <= 6'h15;
    repeat (6) @(posedge clock);
    chk("analog_chan", analog_chan, 6'h15);
    wr(OFS_CMD, 32'h0000_0104);
    rec("01: 0345.67\015");
  endtask

  task automatic t_setup;
    wr(OFS_RATE, 32'h5);
    chk("rate locked", data_rate, RATE_RST);
    wr(OFS_CMD, 32'h2);
    chk("zero refused", zero_pulse, 0);
    wr(OFS_MODE, 32'hE);
    chk("default", sdef, 3'h6);
    wr(OFS_RATE, 32'h5);
    chk("rate", data_rate, 16'h0005);
    wr(OFS_GAIN, 32'h0ABC);
    chk("gain", user_gain, 16'h0ABC);
    wr(OFS_CMD, 32'h2);
    chk("zero", zero_pulse, 1);
  endtask

  task automatic t_single;
    wr(OFS_MODE, 32'h1);
    chk("normal analog", analog_en, 0);
    slow <= 1'b1;
    wr(OFS_CMD, 32'h1);
    rec("08: 0345.67\015");
    slow <= 1'b0;
    repeat (40) @(posedge clock);
    chk("one packet", host.rx.size(), 0);
  endtask

  task automatic t_modes;
    wr(OFS_MODE, 32'h6);
    wr(OFS_FORMAT, 32'h1);
    foreach (ml[i]) begin
      wr(OFS_MODE, 32'(ml[i]));
      rd(OFS_MODE, rv);
      chk("mode", rv[2:0], ml[i]);
      chk("analog_en", analog_en, ml[i] == 3'h0);
    end
    wr(OFS_MODE, 32'h5);
    rd(OFS_MODE, rv);
    chk("delay refused", rv[2:0], 3'h6);
    wr(OFS_MODE, 32'h4);
    rd(OFS_STATUS, rv);
    chk("no stream", rv[1], 0);
    wr(OFS_MODE, 32'hD);
    chk("delay default", sdef, 3'h5);
  endtask

  task automatic t_trig;
    wr(OFS_MODE, 32'h2);
    neg <= 1'b1;
    pulse();
    rec("0891234\015");
    neg <= 1'b0;
  endtask

  task automatic t_polled;
    wr(OFS_MODE, 32'h3);
    repeat (3) @(posedge clock);
    chk("refresh idle", refresh, 0);
    pulse();
    chk("refresh once", nr, 1);
    repeat (40) @(posedge clock);
    chk("polled quiet", host.rx.size(), 0);
    wr(OFS_CMD, 32'h0000_0304);
    rec("03: 0345.67\015");
  endtask

  // mid-run power-up: pins settle while reset is held
  task automatic boot(input logic e, input logic [2:0] m);
    @(posedge clock);
    {srst, eth, mux, smode} <= {1'b1, e, 6'h00, m};
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    host.rx.delete();
    host.rxl.delete();
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic t_stream;
    wr(OFS_MODE, 32'h1);
    wr(OFS_STREAM, 32'h2);
    rd(OFS_STATUS, rv);
    chk("streaming", rv[1], 1);
    chk("rate flag", rv[7], 0);
    repeat (60) @(posedge clock);
    rd(OFS_STATUS, rv);
    chk("timed stop", rv[1], 0);
    repeat (15) @(posedge clock);
    chk("whole records", host.rx.size() % 8, 0);
    rec("0801234\015");
    wr(OFS_STREAM, 32'h1_0000);
    rd(OFS_STATUS, rv);
    chk("endless refused", rv[1], 0);
  endtask

  task automatic t_delay;
    boot(1'b0, 3'h5);
    chk("delay analog", analog_en, 0);
    repeat (570) @(posedge clock);
    rd(OFS_STATUS, rv);
    chk("delay wait", {rv[6], rv[1]}, 2'h2);
    repeat (40) @(posedge clock);
    rd(OFS_STATUS, rv);
    chk("delay start", {rv[6], rv[1]}, 2'h1);
    rec("08: 0345.67\015");
  endtask

  task automatic t_eth;
    boot(1'b1, 3'h4);
    rd(OFS_STATUS, rv);
    chk("eth unit", rv[3], 1);
    chk("eth stream", rv[1], 1);
    rec("08: 0345.67\015");
    wr(OFS_MODE, 32'h6);
    wr(OFS_RATE, 32'h0000_00C8);
    chk("rate clamp", data_rate, TEXT_ETH_MAX_RATE);
    wr(OFS_MODE, 32'h1);
    wr(OFS_STREAM, 32'h1_0000);
    rd(OFS_STATUS, rv);
    chk("endless", rv[1], 1);
    wr(OFS_STREAM, 32'h0);
    rd(OFS_STATUS, rv);
    chk("zero stops", rv[1], 0);
    repeat (30) @(posedge clock);
    host.rx.delete();
    host.rxl.delete();
  endtask

  initial begin
    {srst, reg_wr, reg_rd, eth, trig, slow, neg} = 7'b1000000;
    reg_addr = '0;
    reg_wdata = '0;
    mux = '0;
    smode = 3'h0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    t_boot();
    t_poll();
    t_setup();
    t_single();
    t_modes();
    t_trig();
    t_polled();
    t_stream();
    t_delay();
    t_eth();
    report_and_stop();
  end

  initial begin
    #200000;
    errors++;
    report_and_stop();
  end
endmodule
